// >>> pkg/tmw_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the 8-bit wave timer.
// Assumes: Byte-wide registers on a plain address/strobe port.
// Notes:   Definitions only.
`ifndef TMW_DEFS_SVH
`define TMW_DEFS_SVH

`define TMW_ADDR_W          3
`define TMW_OFS_MODE_CTRL   3'h0
`define TMW_OFS_CLK_CTRL    3'h1
`define TMW_OFS_COUNT       3'h2
`define TMW_OFS_CMP_A       3'h3
`define TMW_OFS_CMP_B       3'h4
`define TMW_OFS_FLAGS       3'h5

`define TMW_BIT_FORCE_A     7
`define TMW_BIT_FORCE_B     6
`define TMW_BIT_MODE_MSB    3
`define TMW_BIT_FLAG_B      2
`define TMW_BIT_FLAG_A      1
`define TMW_BIT_FLAG_OVF    0

`define TMW_RESET_BYTE      8'h00
`define TMW_COUNT_MAX       8'hff
`define TMW_COUNT_BOTTOM    8'h00
`define TMW_PRESC_W         10

`define TMW_MODE_NORMAL     3'h0
`define TMW_MODE_PC_FF      3'h1
`define TMW_MODE_CTC        3'h2
`define TMW_MODE_FAST_FF    3'h3
`define TMW_MODE_PC_CMPA    3'h5
`define TMW_MODE_FAST_CMPA  3'h7

`define TMW_CS_STOP         3'h0
`define TMW_CS_DIV1         3'h1
`define TMW_CS_DIV8         3'h2
`define TMW_CS_DIV64        3'h3
`define TMW_CS_DIV256       3'h4
`define TMW_CS_DIV1024      3'h5
`define TMW_CS_EXT_FALL     3'h6
`define TMW_CS_EXT_RISE     3'h7

`define TMW_TAP_DIV8        10'h007
`define TMW_TAP_DIV64       10'h03f
`define TMW_TAP_DIV256      10'h0ff
`define TMW_TAP_DIV1024     10'h3ff

`endif

// >>> pkg/tmw_pkg.sv
// Purpose: Types of the 8-bit wave timer.
// Assumes: The defs header supplies the prescaler width; other field widths are literal.
// Notes:   The whole timer state is one packed struct.
`default_nettype none
`include "tmw_defs.svh"

package tmw_pkg;

    typedef enum logic {
        TMW_DIR_UP,
        TMW_DIR_DOWN
    } tmw_dir_type;

    typedef struct packed {
        logic [1:0]              act_a;
        logic [1:0]              act_b;
        logic [1:0]              mode_low;
        logic                    mode_msb;
        logic [2:0]              clk_sel;
        logic [7:0]              count;
        logic [7:0]              cmp_a;
        logic [7:0]              cmp_b;
        logic [7:0]              cmp_a_buf;
        logic [7:0]              cmp_b_buf;
        logic                    wave_a;
        logic                    wave_b;
        tmw_dir_type             dir;
        logic                    block_match;
        logic                    flag_ovf;
        logic                    flag_a;
        logic                    flag_b;
        logic [`TMW_PRESC_W-1:0] presc;
        logic                    ext_s1;
        logic                    ext_s2;
        logic                    ext_s3;
        logic [7:0]              rdata;
    } tmw_state_type;

endpackage

`default_nettype wire

// >>> hdl/tmw_timer8.sv
// Purpose: 8-bit timer/counter with two compare channels, wave modes and clock select.
// Assumes: One 100 MHz clock i_mclk also serves as the I/O clock feeding the prescaler.
// Notes:   Register port with read data one cycle after the read strobe.
//
// How it works
// - Non-PWM: B action toggles, clears or sets.
// - Fast PWM: B clears/sets on match, inverse at TOP.
// - Phase-correct: B action depends on count direction.
// - Compare equals TOP: act at TOP only.
// - Mode register bits 3:2 read zero.
// - Three-bit mode picks count sequence and TOP.
// - Compare writes immediate non-PWM, else at TOP.
// - Overflow flag at MAX, BOTTOM or TOP.
// - Force bit makes immediate match in non-PWM.
// - Forced match sets no flag, no clear.
// - Force bits are strobes reading zero.
// - Clock register bits 5:4 read zero.
// - Clock select stops or divides I/O clock.
// - Codes 110/111 count falling/rising pin edges.
// - Pin edges count even when pin output.
// - Counter value readable and writable directly.
// - Counter write blocks next timer-tick match.
// - Mode top bit sits in clock register.
// - Nonzero action drives output over port.
// - B flag clears on vector or one-write.
`default_nettype none
`include "tmw_defs.svh"

module tmw_timer8
    import tmw_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_nrst,
    input  wire logic [`TMW_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    input  wire logic                  i_ext_count_input,
    input  wire logic [2:0]            i_vector_ack,
    output logic                       o_chan_a_wave_out,
    output logic                       o_chan_a_out_en,
    output logic                       o_chan_b_wave_out,
    output logic                       o_chan_b_out_en,
    output logic                       o_overflow_flag,
    output logic                       o_chan_a_match_flag,
    output logic                       o_chan_b_match_flag
);

    tmw_state_type state;
    tmw_state_type next_state;

    // One prescaler tap: high for one cycle every (mask+1) cycles.
    function automatic logic presc_tap(input logic [`TMW_PRESC_W-1:0] cnt,
                                       input logic [`TMW_PRESC_W-1:0] mask);
        presc_tap = (cnt & mask) == mask;
    endfunction

    // Next level of one wave output, shared by both channels.
    function automatic logic wave_step(input logic       cur,
                                       input logic [1:0] act,
                                       input logic       fast,
                                       input logic       pc,
                                       input logic       hit,
                                       input logic       at_top,
                                       input logic       down,
                                       input logic       cmp_top,
                                       input logic       may_toggle);
        logic r;
        r = cur;
        if (!fast && !pc) begin
            if (hit) begin
                case (act)
                    2'h1:    r = ~cur;
                    2'h2:    r = 1'b0;
                    2'h3:    r = 1'b1;
                    default: r = cur;
                endcase
            end
        end else if (act[1]) begin
            if (at_top && (fast || cmp_top)) begin
                r = ~act[0];
            end else if (hit && !cmp_top) begin
                r = (pc && down) ? ~act[0] : act[0];
            end
        end else if (act == 2'h1 && may_toggle && hit) begin
            // Channel A toggles in PWM only with the mode top bit set; channel B treats 01 as a dead code.
            r = ~cur;
        end
        wave_step = r;
    endfunction

    logic [2:0] mode;
    logic       fast;
    logic       pc;
    logic       non_pwm;
    logic       top_from_a;
    logic [7:0] top;
    logic       tick;
    logic       rise;
    logic       fall;
    logic       at_top;
    logic       match_a;
    logic       match_b;
    logic       force_a;
    logic       force_b;
    logic       wr_mode;
    logic       wr_clk;
    logic       wr_count;
    logic       wr_flags;
    logic       ovf_hit;

    always_comb begin
        mode       = {state.mode_msb, state.mode_low};
        fast       = (mode == `TMW_MODE_FAST_FF) || (mode == `TMW_MODE_FAST_CMPA);
        pc         = (mode == `TMW_MODE_PC_FF) || (mode == `TMW_MODE_PC_CMPA);
        non_pwm    = !fast && !pc;
        top_from_a = (mode == `TMW_MODE_CTC) || (mode == `TMW_MODE_PC_CMPA) ||
                     (mode == `TMW_MODE_FAST_CMPA);
        top        = top_from_a ? state.cmp_a : `TMW_COUNT_MAX;

        // Edge detect looks only at the second and third stage of the pin synchroniser.
        rise = state.ext_s2 && !state.ext_s3;
        fall = !state.ext_s2 && state.ext_s3;

        case (state.clk_sel)
            `TMW_CS_DIV1:     tick = 1'b1;
            `TMW_CS_DIV8:     tick = presc_tap(state.presc, `TMW_TAP_DIV8);
            `TMW_CS_DIV64:    tick = presc_tap(state.presc, `TMW_TAP_DIV64);
            `TMW_CS_DIV256:   tick = presc_tap(state.presc, `TMW_TAP_DIV256);
            `TMW_CS_DIV1024:  tick = presc_tap(state.presc, `TMW_TAP_DIV1024);
            `TMW_CS_EXT_FALL: tick = fall;
            `TMW_CS_EXT_RISE: tick = rise;
            default:          tick = 1'b0;
        endcase

        wr_mode  = i_wr && (i_addr == `TMW_OFS_MODE_CTRL);
        wr_clk   = i_wr && (i_addr == `TMW_OFS_CLK_CTRL);
        wr_count = i_wr && (i_addr == `TMW_OFS_COUNT);
        wr_flags = i_wr && (i_addr == `TMW_OFS_FLAGS);

        // Force strobes act only in non-PWM modes and are never stored.
        force_a = wr_clk && i_wdata[`TMW_BIT_FORCE_A] && non_pwm;
        force_b = wr_clk && i_wdata[`TMW_BIT_FORCE_B] && non_pwm;

        at_top  = tick && (state.count == top);
        match_a = tick && !state.block_match && (state.count == state.cmp_a);
        match_b = tick && !state.block_match && (state.count == state.cmp_b);

        case (mode)
            `TMW_MODE_NORMAL, `TMW_MODE_CTC, `TMW_MODE_FAST_FF:
                ovf_hit = tick && (state.count == `TMW_COUNT_MAX);
            `TMW_MODE_PC_FF, `TMW_MODE_PC_CMPA:
                ovf_hit = tick && (state.count == `TMW_COUNT_BOTTOM);
            `TMW_MODE_FAST_CMPA:
                ovf_hit = at_top;
            default:
                ovf_hit = tick && (state.count == `TMW_COUNT_MAX);
        endcase

        next_state = state;

        // The prescaler runs free so that taps keep a steady phase across source changes.
        next_state.presc  = state.presc + `TMW_PRESC_W'(1);
        next_state.ext_s1 = i_ext_count_input;
        next_state.ext_s2 = state.ext_s1;
        next_state.ext_s3 = state.ext_s2;

        // Counter sequence.
        if (tick) begin
            next_state.block_match = 1'b0;
            if (pc) begin
                if (state.dir == TMW_DIR_UP) begin
                    if (state.count == top) begin
                        next_state.dir   = TMW_DIR_DOWN;
                        next_state.count = state.count - 8'h01;
                    end else begin
                        next_state.count = state.count + 8'h01;
                    end
                end else begin
                    if (state.count == `TMW_COUNT_BOTTOM) begin
                        next_state.dir   = TMW_DIR_UP;
                        next_state.count = state.count + 8'h01;
                    end else begin
                        next_state.count = state.count - 8'h01;
                    end
                end
            end else if (top_from_a && (state.count == top)) begin
                // Only a real match clears the counter; a forced one does not.
                next_state.count = `TMW_COUNT_BOTTOM;
            end else begin
                next_state.count = state.count + 8'h01;
            end
        end

        // Double-buffered compare values load at TOP in PWM modes.
        if (!non_pwm && at_top) begin
            next_state.cmp_a = state.cmp_a_buf;
            next_state.cmp_b = state.cmp_b_buf;
        end

        next_state.wave_a = wave_step(state.wave_a, state.act_a, fast, pc,
                                      match_a || force_a, at_top,
                                      state.dir == TMW_DIR_DOWN,
                                      state.cmp_a == top, state.mode_msb);
        next_state.wave_b = wave_step(state.wave_b, state.act_b, fast, pc,
                                      match_b || force_b, at_top,
                                      state.dir == TMW_DIR_DOWN,
                                      state.cmp_b == top, 1'b0);

        // Flags: write-one or vector clears, but a same-cycle event wins.
        if (wr_flags && i_wdata[`TMW_BIT_FLAG_OVF] || i_vector_ack[`TMW_BIT_FLAG_OVF]) begin
            next_state.flag_ovf = 1'b0;
        end
        if (wr_flags && i_wdata[`TMW_BIT_FLAG_A] || i_vector_ack[`TMW_BIT_FLAG_A]) begin
            next_state.flag_a = 1'b0;
        end
        if (wr_flags && i_wdata[`TMW_BIT_FLAG_B] || i_vector_ack[`TMW_BIT_FLAG_B]) begin
            next_state.flag_b = 1'b0;
        end
        if (ovf_hit) begin
            next_state.flag_ovf = 1'b1;
        end
        if (match_a) begin
            next_state.flag_a = 1'b1;
        end
        if (match_b) begin
            next_state.flag_b = 1'b1;
        end

        // Register writes.
        if (wr_mode) begin
            next_state.act_a    = i_wdata[7:6];
            next_state.act_b    = i_wdata[5:4];
            next_state.mode_low = i_wdata[1:0];
        end
        if (wr_clk) begin
            next_state.mode_msb = i_wdata[`TMW_BIT_MODE_MSB];
            next_state.clk_sel  = i_wdata[2:0];
        end
        if (wr_count) begin
            // A software write overrides a same-cycle count step.
            next_state.count       = i_wdata;
            next_state.block_match = 1'b1;
        end
        if (i_wr && (i_addr == `TMW_OFS_CMP_A)) begin
            next_state.cmp_a_buf = i_wdata;
            if (non_pwm) begin
                next_state.cmp_a = i_wdata;
            end
        end
        if (i_wr && (i_addr == `TMW_OFS_CMP_B)) begin
            next_state.cmp_b_buf = i_wdata;
            if (non_pwm) begin
                next_state.cmp_b = i_wdata;
            end
        end

        // Read data for the cycle after the strobe; unmapped offsets read zero.
        next_state.rdata = `TMW_RESET_BYTE;
        if (i_rd) begin
            case (i_addr)
                `TMW_OFS_MODE_CTRL: next_state.rdata = {state.act_a, state.act_b, 2'h0,
                                                        state.mode_low};
                `TMW_OFS_CLK_CTRL:  next_state.rdata = {2'h0, 2'h0, state.mode_msb,
                                                        state.clk_sel};
                `TMW_OFS_COUNT:     next_state.rdata = state.count;
                `TMW_OFS_CMP_A:     next_state.rdata = state.cmp_a_buf;
                `TMW_OFS_CMP_B:     next_state.rdata = state.cmp_b_buf;
                `TMW_OFS_FLAGS:     next_state.rdata = {5'h00, state.flag_b, state.flag_a,
                                                        state.flag_ovf};
                default:            next_state.rdata = `TMW_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        o_rdata             = state.rdata;
        o_chan_a_wave_out   = state.wave_a;
        o_chan_b_wave_out   = state.wave_b;
        o_chan_a_out_en     = |state.act_a;
        o_chan_b_out_en     = |state.act_b;
        o_overflow_flag     = state.flag_ovf;
        o_chan_a_match_flag = state.flag_a;
        o_chan_b_match_flag = state.flag_b;
    end

endmodule

`default_nettype wire

// >>> verification/tmw_timer8_sva.sv
// Purpose: Port-level assertions for the 8-bit wave timer.
// Assumes: Control registers change only through the strobe port.
// Notes:   Shadows of control writes tell the properties the mode and source.
`default_nettype none
`include "tmw_defs.svh"

module tmw_timer8_sva (
    input wire logic                   i_mclk,
    input wire logic                   i_nrst,
    input wire logic [`TMW_ADDR_W-1:0] i_addr,
    input wire logic [7:0]             i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [7:0]             o_rdata,
    input wire logic                   i_ext_count_input,
    input wire logic [2:0]             i_vector_ack,
    input wire logic                   o_chan_a_wave_out,
    input wire logic                   o_chan_a_out_en,
    input wire logic                   o_chan_b_wave_out,
    input wire logic                   o_chan_b_out_en,
    input wire logic                   o_overflow_flag,
    input wire logic                   o_chan_a_match_flag,
    input wire logic                   o_chan_b_match_flag
);
    logic [7:0] mode_q;
    logic [7:0] clk_q;
    logic [7:0] wd_q;
    logic       stopped;
    logic       frc_b;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode_q <= 8'h00;
            clk_q  <= 8'h00;
            wd_q   <= 8'h00;
        end else begin
            wd_q <= i_wdata;
            if (i_wr && i_addr == `TMW_OFS_MODE_CTRL) mode_q <= i_wdata;
            if (i_wr && i_addr == `TMW_OFS_CLK_CTRL) clk_q <= i_wdata;
        end
    end

    assign stopped = clk_q[2:0] == `TMW_CS_STOP;
    assign frc_b   = i_wr && i_addr == `TMW_OFS_CLK_CTRL && i_wdata[`TMW_BIT_FORCE_B];

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);

    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
    property p_mode_rsvd;
        $past(i_rd) && $past(i_addr) == `TMW_OFS_MODE_CTRL |-> o_rdata[3:2] == 2'b00;
    endproperty
    a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode register bits 3:2 not zero");
    property p_clk_rsvd;
        $past(i_rd) && $past(i_addr) == `TMW_OFS_CLK_CTRL |-> o_rdata[7:4] == 4'h0;
    endproperty
    a_clk_rsvd: assert property (p_clk_rsvd) else $error("clock register bits 7:4 not zero");
    property p_out_en;
        i_wr && i_addr == `TMW_OFS_MODE_CTRL |=>
            o_chan_b_out_en == (wd_q[5:4] != 2'b00) && o_chan_a_out_en == (wd_q[7:6] != 2'b00);
    endproperty
    a_out_en: assert property (p_out_en) else $error("output enable does not follow action bits");
    property p_stop_no_ovf;
        stopped && !o_overflow_flag |=> !o_overflow_flag;
    endproperty
    a_stop_no_ovf: assert property (p_stop_no_ovf) else $error("overflow while stopped");
    property p_flag_b_clear;
        (i_vector_ack[2] || (i_wr && i_addr == `TMW_OFS_FLAGS && i_wdata[2])) && stopped |=> !o_chan_b_match_flag;
    endproperty
    a_flag_b_clear: assert property (p_flag_b_clear) else $error("flag b not cleared");
    property p_force_no_flag;
        frc_b && stopped && !o_chan_b_match_flag |=> !o_chan_b_match_flag [*3];
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) else $error("forced match set flag b");
    property p_force_action;
        frc_b && stopped && !mode_q[0] && mode_q[5:4] != 2'b00 |=>
            o_chan_b_wave_out == (mode_q[5:4] == 2'b01 ? !$past(o_chan_b_wave_out) : mode_q[4]);
    endproperty
    a_force_action: assert property (p_force_action) else $error("forced match wrong b level");
    property p_pwm_no_force;
        frc_b && stopped && mode_q[0] |=> $stable(o_chan_b_wave_out);
    endproperty
    a_pwm_no_force: assert property (p_pwm_no_force) else $error("force acted in pwm mode");

    c_force: cover property (frc_b && stopped && !mode_q[0]);
    c_ovf: cover property ($rose(o_overflow_flag));
    c_flag_b: cover property ($rose(o_chan_b_match_flag));
endmodule

bind tmw_timer8 tmw_timer8_sva u_sva (.i_mclk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ext_count_input, .i_vector_ack, .o_chan_a_wave_out, .o_chan_a_out_en, .o_chan_b_wave_out,
    .o_chan_b_out_en, .o_overflow_flag, .o_chan_a_match_flag, .o_chan_b_match_flag);

`default_nettype wire

// >>> verification/tmw_timer8_test.sv
// Purpose: Self-checking bench of the 8-bit wave timer.
// Assumes: One 100 MHz clock; registers reached through the strobe port.
// Notes:   Prescaler phase is free running, so divided counts get one tick of slack.
`default_nettype none
`include "tmw_defs.svh"

module tmw_timer8_test;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [2:0] a; logic [7:0] w; logic [7:0] e;} tmw_row_type;
    typedef struct packed {logic [7:0] mode; logic [7:0] cmp; logic [15:0] per; logic [15:0] ones;} tmw_pwm_type;

    logic                   i_mclk;
    logic                   i_nrst;
    logic [`TMW_ADDR_W-1:0] i_addr;
    logic [7:0]             i_wdata;
    logic                   i_wr;
    logic                   i_rd;
    logic [7:0]             o_rdata;
    logic                   i_ext_count_input;
    logic [2:0]             i_vector_ack;
    logic                   o_chan_a_wave_out;
    logic                   o_chan_a_out_en;
    logic                   o_chan_b_wave_out;
    logic                   o_chan_b_out_en;
    logic                   o_overflow_flag;
    logic                   o_chan_a_match_flag;
    logic                   o_chan_b_match_flag;
    logic [6:0]             outs;
    int                     mismatches;
    int                     checks;

    tmw_row_type rows [8] = '{'{3'h0, 8'hff, 8'hf3}, '{3'h1, 8'hff, 8'h0f}, '{3'h1, 8'h00, 8'h00},
        '{3'h0, 8'h00, 8'h00}, '{3'h2, 8'h5a, 8'h5a}, '{3'h3, 8'hc3, 8'hc3}, '{3'h6, 8'hff, 8'h00},
        '{3'h7, 8'h11, 8'h00}};
    tmw_pwm_type pwm [5] = '{'{8'h23, 8'h80, 16'h0100, 16'h0081}, '{8'h33, 8'h80, 16'h0100, 16'h007f},
        '{8'h23, 8'hff, 16'h0100, 16'h0100}, '{8'h21, 8'h80, 16'h01fe, 16'h0100},
        '{8'h31, 8'h80, 16'h01fe, 16'h00fe}};
    int divs [5] = '{1, 8, 64, 256, 1024};

    assign outs = {o_chan_a_wave_out, o_chan_a_out_en, o_chan_b_wave_out, o_chan_b_out_en,
                   o_overflow_flag, o_chan_a_match_flag, o_chan_b_match_flag};

    tmw_timer8 u_dut (.i_mclk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ext_count_input,
        .i_vector_ack, .o_chan_a_wave_out, .o_chan_a_out_en, .o_chan_b_wave_out, .o_chan_b_out_en,
        .o_overflow_flag, .o_chan_a_match_flag, .o_chan_b_match_flag);

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic rdchk(input string name, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(name, d, e);
    endtask

    task automatic end_sim;
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    initial begin
        #500us;
        mismatches++;
        end_sim();
    end

    initial begin
        logic [7:0] d;
        logic       prev;
        logic       preva;
        int         ones;
        i_nrst = 1'b0;
        i_addr = '0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_ext_count_input = 1'b0;
        i_vector_ack = 3'h0;
        mismatches = 0;
        checks = 0;
        repeat (6) @(posedge i_mclk);
        i_nrst <= 1'b1;
        #1;
        chk("reset_outs", outs, 7'h00);
        for (int k = 0; k < 3; k++) rdchk("reset_reg", 3'(k), 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdchk("reg_rw", rows[i].a, rows[i].e);
        end
        for (int k = 3; k >= 1; k--) begin
            wr(`TMW_OFS_MODE_CTRL, 8'((k << 4) | (k << 6)));
            prev = o_chan_b_wave_out;
            preva = o_chan_a_wave_out;
            wr(`TMW_OFS_CLK_CTRL, 8'hc0);
            chk("force_wave", o_chan_b_wave_out, k == 1 ? !prev : k[0]);
            chk("force_wave_a", o_chan_a_wave_out, k == 1 ? !preva : k[0]);
            chk("force_flag_a", o_chan_a_match_flag, 1'b0);
            chk("force_flag", o_chan_b_match_flag, 1'b0);
        end
        wr(`TMW_OFS_CMP_B, 8'h05);
        wr(`TMW_OFS_COUNT, 8'h00);
        prev = o_chan_b_wave_out;
        wr(`TMW_OFS_CLK_CTRL, `TMW_CS_DIV1);
        repeat (20) @(posedge i_mclk);
        wr(`TMW_OFS_CLK_CTRL, `TMW_CS_STOP);
        chk("match_wave", o_chan_b_wave_out, !prev);
        chk("match_flag", o_chan_b_match_flag, 1'b1);
        @(posedge i_mclk);
        i_vector_ack <= 3'h4;
        @(posedge i_mclk);
        i_vector_ack <= 3'h0;
        #1;
        chk("vector_clear", o_chan_b_match_flag, 1'b0);
        wr(`TMW_OFS_CMP_B, 8'h07);
        wr(`TMW_OFS_COUNT, 8'h07);
        wr(`TMW_OFS_CLK_CTRL, `TMW_CS_DIV1);
        repeat (8) @(posedge i_mclk);
        wr(`TMW_OFS_CLK_CTRL, `TMW_CS_STOP);
        chk("write_blocks", o_chan_b_match_flag, 1'b0);
        for (int k = 0; k < 5; k++) begin
            wr(`TMW_OFS_COUNT, 8'h00);
            wr(`TMW_OFS_CLK_CTRL, 8'(k + 1));
            repeat (4 * divs[k] - 2) @(posedge i_mclk);
            wr(`TMW_OFS_CLK_CTRL, `TMW_CS_STOP);
            rd(`TMW_OFS_COUNT, d);
            chk("presc_ticks", d >= 8'h03 && d <= 8'h05, 1'b1);
        end
        for (int k = 6; k <= 7; k++) begin
            wr(`TMW_OFS_COUNT, 8'h00);
            wr(`TMW_OFS_CLK_CTRL, 8'(k));
            repeat (3) begin
                repeat (6) @(posedge i_mclk);
                i_ext_count_input <= 1'b1;
                repeat (6) @(posedge i_mclk);
                i_ext_count_input <= 1'b0;
            end
            repeat (6) @(posedge i_mclk);
            wr(`TMW_OFS_CLK_CTRL, `TMW_CS_STOP);
            rdchk("ext_edges", `TMW_OFS_COUNT, 8'h03);
        end
        foreach (pwm[i]) begin
            wr(`TMW_OFS_CLK_CTRL, `TMW_CS_STOP);
            wr(`TMW_OFS_MODE_CTRL, pwm[i].mode);
            wr(`TMW_OFS_CMP_B, pwm[i].cmp);
            wr(`TMW_OFS_FLAGS, 8'h07);
            wr(`TMW_OFS_CLK_CTRL, `TMW_CS_DIV1);
            repeat (600) @(posedge i_mclk);
            ones = 0;
            repeat (pwm[i].per) begin
                @(posedge i_mclk);
                #1;
                ones += int'(o_chan_b_wave_out);
            end
            chk("pwm_high", 16'(ones), pwm[i].ones);
            chk("pwm_ovf", o_overflow_flag, 1'b1);
        end
        @(posedge i_mclk);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_nrst <= 1'b1;
        #1;
        chk("rerun_outs", outs, 7'h00);
        rdchk("rerun_count", `TMW_OFS_COUNT, 8'h00);
        end_sim();
    end
endmodule

`default_nettype wire
